// [core/cbl_defs.vh]
// Constants for the complement / decimal adjust / loop / enable execute slice.
// Included by the slice core and its decimal adjust helper; definitions only.
`ifndef CBL_DEFS_VH
`define CBL_DEFS_VH

// Opcodes handled by this slice
`define CBL_OP_COMPL_ACC     8'h37
`define CBL_OP_COMPL_CARRY   8'hA7
`define CBL_OP_COMPL_UF0     8'h95
`define CBL_OP_COMPL_UF1     8'hB5
`define CBL_OP_DEC_ADJ       8'h57
`define CBL_OP_DBNZ_MASK     8'hF8
`define CBL_OP_DBNZ_BASE     8'hE8
`define CBL_OP_EXT_IRQ_EN    8'h05
`define CBL_OP_TMR_IRQ_EN    8'h25
`define CBL_OP_CLK_OUT_EN    8'h75

// Decimal adjust figures
`define CBL_BCD_LIMIT        4'h9
`define CBL_BCD_CORR         4'h6

// Register map (word index on the plain port)
`define CBL_REG_ACC          4'h0
`define CBL_REG_PSW          4'h1
`define CBL_REG_CTRL         4'h2
`define CBL_REG_PC_LO        4'h3
`define CBL_REG_PC_HI        4'h4
`define CBL_REG_STAT         4'h5
`define CBL_REG_WR_BASE      4'h8

// Status word fields
`define CBL_PSW_CARRY        7
`define CBL_PSW_AUX          6
`define CBL_PSW_UF0          5
`define CBL_PSW_UF1          4

// Control register fields
`define CBL_CTRL_EXT_EN      0
`define CBL_CTRL_TMR_EN      1
`define CBL_CTRL_CLK_EN      2

// Reset values
`define CBL_RST_BYTE         8'h00
`define CBL_RST_PC           12'h000

// Timing in core clocks
`define CBL_DBNZ_CYCLES      2

`endif

// [core/cbl_dec_adj.v]
// Decimal adjust datapath: two nibble corrections of the accumulator.
// Purely combinational; the caller registers the results.
`timescale 1ns/10ps
`default_nettype none
`include "cbl_defs.vh"

module cbl_dec_adj (
  input  wire [7:0] i_acc,        // Accumulator before adjust
  input  wire       i_carry,      // Carry flag before adjust
  input  wire       i_aux_carry,  // Auxiliary carry flag
  output reg  [7:0] o_acc,        // Adjusted accumulator
  output reg        o_carry       // Carry flag after adjust
);

  reg [8:0] sum_lo;
  reg [8:0] sum_hi;
  reg       hi_fix;

  always @*
  begin
    sum_lo = {1'b0, i_acc};
    if ((i_acc[3:0] > `CBL_BCD_LIMIT) || i_aux_carry)
    begin
      sum_lo = {1'b0, i_acc} + {5'h00, `CBL_BCD_CORR};
    end
    hi_fix = (sum_lo[7:4] > `CBL_BCD_LIMIT) || i_carry || sum_lo[8];
    sum_hi = {1'b0, sum_lo[7:0]};
    if (hi_fix)
    begin
      sum_hi = {1'b0, sum_lo[7:0]} + {1'b0, `CBL_BCD_CORR, 4'h0};
    end
    o_acc = sum_hi[7:0];
    o_carry = i_carry | sum_hi[8] | sum_lo[8];
  end

endmodule // cbl_dec_adj

`default_nettype wire

// [core/cbl_exec.v]
// Execute slice for complement, decimal adjust, loop branch and enable opcodes.
// Fetch path presents one opcode with its second byte and own address on an
// issue strobe; software reaches the state over a plain register port.
//
// Behaviour
// - Complementing the accumulator inverts every bit and leaves flags alone.
// - Complementing the carry inverts carry and leaves the accumulator alone.
// - Opcode 1001 0101 inverts user flag zero and nothing else.
// - The user flag one complement inverts that flag and nothing else.
// - Decimal adjust first adds 6 when the low nibble exceeds 9 or aux carry is set.
// - Then 6 is added to the high nibble when it now exceeds 9, carry is set or the low step carried out.
// - An overflow of the high nibble correction sets carry.
// - Decrement-and-branch decrements register r (opcode low bits) in two cycles.
// - A nonzero result loads the second byte into the low PC byte, upper bits from the address after the opcode.
// - The external interrupt enable opcode lets external requests through.
// - The clock output enable opcode starts driving the clock on the test pin.
// - Reset turns the test pin clock off until the enable opcode runs or software sets the control bit.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "cbl_defs.vh"

module cbl_exec (
  input  wire        i_mclk,              // Core clock, 250 MHz
  input  wire        i_nrst,              // Synchronous reset, active low
  // Instruction issue
  input  wire        i_issue,             // Opcode valid, one-cycle pulse
  input  wire [7:0]  i_opcode,            // First instruction byte
  input  wire [7:0]  i_operand,           // Second instruction byte
  input  wire [11:0] i_op_pc,             // Address of the first byte
  output wire        o_ready,             // Slice can take an issue
  output reg         o_done_ff,           // Instruction retired, pulse
  output reg         o_unknown_ff,        // Opcode not of this slice, pulse
  // Architectural state views
  output reg  [7:0]  o_acc_ff,            // Accumulator
  output reg         o_carry_ff,          // Carry flag
  output reg         o_aux_carry_flag_ff, // Auxiliary carry flag
  output reg         o_user_flag_zero_ff, // User flag zero
  output reg         o_user_flag_one_ff,  // User flag one
  output reg  [11:0] o_pc_ff,             // Program counter
  // Interrupt sources and gated requests
  input  wire        i_ext_irq_n,         // External interrupt input, low active
  input  wire        i_tmr_overflow,      // Timer overflow pulse
  output reg         o_ext_irq_en_ff,     // External interrupt enable
  output reg         o_tmr_irq_en_ff,     // Timer interrupt enable
  output wire        o_ext_irq_req,       // Gated external request
  output wire        o_tmr_irq_req,       // Gated timer request
  // Test pin clock output
  input  wire        i_test_zero_pin,     // Test pin level in
  output reg         o_test_zero_pin_ff,  // Test pin drive value
  output reg         o_test_zero_pin_oe,  // Test pin drive enable
  // Register port
  input  wire [3:0]  i_addr,              // Register index
  input  wire [7:0]  i_wdata,             // Write data
  input  wire        i_wr,                // Write strobe
  input  wire        i_rd,                // Read strobe
  output reg  [7:0]  o_rdata_ff           // Read data, cycle after strobe
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_BR   = 2'b10;

  reg [1:0]  state_ff;
  reg [1:0]  nxt_state;
  reg [7:0]  wreg_ff [0:7];
  reg [2:0]  sel_ff;
  reg [7:0]  target_ff;
  reg [11:0] base_pc_ff;
  reg        nz_ff;
  reg        clk_out_en_ff;
  reg        tmr_pend_ff;
  reg        test_zero_seen_ff;

  wire [7:0] adj_acc;
  wire       adj_carry;
  wire       take;
  wire       is_dbnz;
  wire [2:0] working_register_sel;
  wire [7:0] dec_val;
  wire [11:0] next_pc;
  wire [11:0] skip_pc;

  cbl_dec_adj u_dec_adj (
    .i_acc       (o_acc_ff),
    .i_carry     (o_carry_ff),
    .i_aux_carry (o_aux_carry_flag_ff),
    .o_acc       (adj_acc),
    .o_carry     (adj_carry)
  );

  // Issues during the branch cycle are not accepted
  assign o_ready = state_ff[0];
  assign take = i_issue & o_ready;
  assign is_dbnz = ((i_opcode & `CBL_OP_DBNZ_MASK) == `CBL_OP_DBNZ_BASE);
  assign working_register_sel = i_opcode[2:0];
  assign dec_val = wreg_ff[working_register_sel] - 8'h01;
  assign next_pc = i_op_pc + 12'h001;
  assign skip_pc = i_op_pc + 12'h002;

  assign o_ext_irq_req = o_ext_irq_en_ff & ~i_ext_irq_n;
  assign o_tmr_irq_req = tmr_pend_ff;

  always @*
  begin
    case (state_ff)
      ST_IDLE: nxt_state = (take && is_dbnz) ? ST_BR : ST_IDLE;
      ST_BR:   nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge i_mclk)
  begin
    if (!i_nrst)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Working registers, one generate entry each; issue wins over the bus
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_wreg
      always @(posedge i_mclk)
      begin
        if (!i_nrst)
        begin
          wreg_ff[gi] <= `CBL_RST_BYTE;
        end
        else if (take && is_dbnz && (working_register_sel == gi))
        begin
          wreg_ff[gi] <= dec_val;
        end
        else if (i_wr && (i_addr == (`CBL_REG_WR_BASE + gi)))
        begin
          wreg_ff[gi] <= i_wdata;
        end
      end
    end
  endgenerate

  // Branch bookkeeping captured in the first cycle
  always @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      sel_ff     <= 3'h0;
      target_ff  <= `CBL_RST_BYTE;
      base_pc_ff <= `CBL_RST_PC;
      nz_ff      <= 1'b0;
    end
    else if (take && is_dbnz)
    begin
      sel_ff     <= working_register_sel;
      target_ff  <= i_operand;
      // page of the byte after the opcode
      base_pc_ff <= next_pc;
      nz_ff      <= (dec_val != 8'h00);
    end
  end

  // Accumulator and flags
  always @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      o_acc_ff            <= `CBL_RST_BYTE;
      o_carry_ff          <= 1'b0;
      o_aux_carry_flag_ff <= 1'b0;
      o_user_flag_zero_ff <= 1'b0;
      o_user_flag_one_ff  <= 1'b0;
    end
    else
    begin
      if (i_wr && (i_addr == `CBL_REG_ACC))
        o_acc_ff <= i_wdata;
      if (i_wr && (i_addr == `CBL_REG_PSW))
      begin
        o_carry_ff          <= i_wdata[`CBL_PSW_CARRY];
        o_aux_carry_flag_ff <= i_wdata[`CBL_PSW_AUX];
        o_user_flag_zero_ff <= i_wdata[`CBL_PSW_UF0];
        o_user_flag_one_ff  <= i_wdata[`CBL_PSW_UF1];
      end
      if (take)
      begin
        case (i_opcode)
          `CBL_OP_COMPL_ACC:   o_acc_ff <= ~o_acc_ff;
          `CBL_OP_COMPL_CARRY: o_carry_ff <= ~o_carry_ff;
          `CBL_OP_COMPL_UF0:   o_user_flag_zero_ff <= ~o_user_flag_zero_ff;
          `CBL_OP_COMPL_UF1:   o_user_flag_one_ff <= ~o_user_flag_one_ff;
          `CBL_OP_DEC_ADJ:
          begin
            o_acc_ff   <= adj_acc;
            o_carry_ff <= adj_carry;
          end
          default:             o_acc_ff <= o_acc_ff;
        endcase
      end
    end
  end

  // Program counter
  always @(posedge i_mclk)
  begin
    if (!i_nrst)
      o_pc_ff <= `CBL_RST_PC;
    else if (state_ff[1] && nz_ff)
      o_pc_ff <= {base_pc_ff[11:8], target_ff};
    else if (state_ff[1])
      o_pc_ff <= base_pc_ff + 12'h001;
    else if (take && !is_dbnz)
      o_pc_ff <= next_pc;
    else if (i_wr && (i_addr == `CBL_REG_PC_LO))
      o_pc_ff <= {o_pc_ff[11:8], i_wdata};
    else if (i_wr && (i_addr == `CBL_REG_PC_HI))
      o_pc_ff <= {i_wdata[3:0], o_pc_ff[7:0]};
  end

  // Enables; set by opcodes or software, cleared by software or reset
  always @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      o_ext_irq_en_ff <= 1'b0;
      o_tmr_irq_en_ff <= 1'b0;
      clk_out_en_ff   <= 1'b0;
    end
    else
    begin
      if (i_wr && (i_addr == `CBL_REG_CTRL))
      begin
        o_ext_irq_en_ff <= i_wdata[`CBL_CTRL_EXT_EN];
        o_tmr_irq_en_ff <= i_wdata[`CBL_CTRL_TMR_EN];
        clk_out_en_ff   <= i_wdata[`CBL_CTRL_CLK_EN];
      end
      if (take && (i_opcode == `CBL_OP_EXT_IRQ_EN))
      begin
        o_ext_irq_en_ff <= 1'b1;
      end
      if (take && (i_opcode == `CBL_OP_TMR_IRQ_EN))
      begin
        o_tmr_irq_en_ff <= 1'b1;
      end
      if (take && (i_opcode == `CBL_OP_CLK_OUT_EN))
      begin
        clk_out_en_ff <= 1'b1;
      end
    end
  end

  // Pending timer request; a new overflow wins over the software clear
  always @(posedge i_mclk)
  begin
    if (!i_nrst)
      tmr_pend_ff <= 1'b0;
    else if (i_tmr_overflow && o_tmr_irq_en_ff)
      tmr_pend_ff <= 1'b1;
    else if (!o_tmr_irq_en_ff)
      tmr_pend_ff <= 1'b0;
    else if (i_wr && (i_addr == `CBL_REG_STAT) && i_wdata[0])
      tmr_pend_ff <= 1'b0;
  end

  // Test pin clock: a full-rate clock cannot come from a flop, so half rate
  always @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      o_test_zero_pin_ff <= 1'b0;
      o_test_zero_pin_oe <= 1'b0;
      test_zero_seen_ff  <= 1'b0;
    end
    else
    begin
      o_test_zero_pin_oe <= clk_out_en_ff;
      o_test_zero_pin_ff <= clk_out_en_ff & ~o_test_zero_pin_ff;
      test_zero_seen_ff  <= i_test_zero_pin;
    end
  end

  // Retire and unknown-opcode pulses
  always @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      o_done_ff    <= 1'b0;
      o_unknown_ff <= 1'b0;
    end
    else
    begin
      o_done_ff    <= (take && !is_dbnz) || state_ff[1];
      o_unknown_ff <= take && !is_dbnz &&
                      (i_opcode != `CBL_OP_COMPL_ACC) &&
                      (i_opcode != `CBL_OP_COMPL_CARRY) &&
                      (i_opcode != `CBL_OP_COMPL_UF0) &&
                      (i_opcode != `CBL_OP_COMPL_UF1) &&
                      (i_opcode != `CBL_OP_DEC_ADJ) &&
                      (i_opcode != `CBL_OP_EXT_IRQ_EN) &&
                      (i_opcode != `CBL_OP_TMR_IRQ_EN) &&
                      (i_opcode != `CBL_OP_CLK_OUT_EN);
    end
  end

  // Register reads, data in the following cycle only
  always @(posedge i_mclk)
  begin
    if (!i_nrst)
      o_rdata_ff <= `CBL_RST_BYTE;
    else if (!i_rd)
      o_rdata_ff <= `CBL_RST_BYTE;
    else if (i_addr[3])
      o_rdata_ff <= wreg_ff[i_addr[2:0]];
    else
    begin
      case (i_addr)
        `CBL_REG_ACC:   o_rdata_ff <= o_acc_ff;
        `CBL_REG_PSW:   o_rdata_ff <= {o_carry_ff, o_aux_carry_flag_ff,
                                       o_user_flag_zero_ff, o_user_flag_one_ff,
                                       4'h0};
        `CBL_REG_CTRL:  o_rdata_ff <= {5'h00, clk_out_en_ff,
                                       o_tmr_irq_en_ff, o_ext_irq_en_ff};
        `CBL_REG_PC_LO: o_rdata_ff <= o_pc_ff[7:0];
        `CBL_REG_PC_HI: o_rdata_ff <= {4'h0, o_pc_ff[11:8]};
        `CBL_REG_STAT:  o_rdata_ff <= {4'h0, test_zero_seen_ff, state_ff[1],
                                       o_ext_irq_req, tmr_pend_ff};
        default:        o_rdata_ff <= `CBL_RST_BYTE;
      endcase
    end
  end

endmodule // cbl_exec

`default_nettype wire

// [testbench/cbl_exec_properties.sv]
// Concurrent checks on the execute slice ports.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
`include "cbl_defs.vh"
module cbl_exec_chk (
  input wire logic        i_mclk,              // Core clock
  input wire logic        i_nrst,              // Reset, active low
  input wire logic        i_issue,             // Issue strobe
  input wire logic [7:0]  i_opcode,            // First byte
  input wire logic [7:0]  i_operand,           // Second byte
  input wire logic [11:0] i_op_pc,             // Opcode address
  input wire logic        o_ready,             // Idle
  input wire logic        o_done_ff,           // Retired
  input wire logic [7:0]  o_acc_ff,            // Accumulator
  input wire logic        o_carry_ff,          // Carry
  input wire logic        o_user_flag_zero_ff, // User flag zero
  input wire logic        o_user_flag_one_ff,  // User flag one
  input wire logic [11:0] o_pc_ff,             // Program counter
  input wire logic        i_tmr_overflow,      // Timer overflow
  input wire logic        o_ext_irq_en_ff,     // External enable
  input wire logic        o_tmr_irq_en_ff,     // Timer enable
  input wire logic        o_tmr_irq_req,       // Timer request
  input wire logic        o_test_zero_pin_oe   // Test pin drive enable
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  wire logic        take = i_issue && o_ready;
  wire logic        dbnz = take && ((i_opcode & `CBL_OP_DBNZ_MASK) == `CBL_OP_DBNZ_BASE);
  wire logic [11:0] pc_step = i_op_pc + 12'h001;
  acc_invert_a: assert property (take && i_opcode == `CBL_OP_COMPL_ACC
    |=> o_acc_ff == ~$past(o_acc_ff) && $stable(o_carry_ff)) else $error("acc complement wrong");
  carry_invert_a: assert property (take && i_opcode == `CBL_OP_COMPL_CARRY
    |=> o_carry_ff != $past(o_carry_ff) && $stable(o_acc_ff)) else $error("carry complement wrong");
  uf0_invert_a: assert property (take && i_opcode == `CBL_OP_COMPL_UF0
    |=> o_user_flag_zero_ff != $past(o_user_flag_zero_ff) && $stable(o_acc_ff)
    && $stable(o_carry_ff) && $stable(o_user_flag_one_ff)) else $error("flag zero complement wrong");
  uf1_invert_a: assert property (take && i_opcode == `CBL_OP_COMPL_UF1
    |=> o_user_flag_one_ff != $past(o_user_flag_one_ff) && $stable(o_acc_ff)
    && $stable(o_user_flag_zero_ff)) else $error("flag one complement wrong");
  adjust_carry_a: assert property (take && i_opcode == `CBL_OP_DEC_ADJ &&
    (o_carry_ff || (o_acc_ff[7:4] >= 4'h9 && o_acc_ff[3:0] > 4'h9)) |=> o_carry_ff)
    else $error("adjust carry wrong");
  loop_timing_a: assert property (dbnz |=> !o_ready ##1 (o_ready && o_done_ff))
    else $error("loop branch timing wrong");
  loop_target_a: assert property (dbnz |=> ##1
    (o_pc_ff == {$past(pc_step[11:8], 2), $past(i_operand, 2)}
    || o_pc_ff == $past(i_op_pc, 2) + 12'h002)) else $error("loop target wrong");
  ext_enable_a: assert property (take && i_opcode == `CBL_OP_EXT_IRQ_EN
    |=> o_ext_irq_en_ff) else $error("external enable not set");
  tmr_request_a: assert property (o_tmr_irq_en_ff && i_tmr_overflow
    |=> o_tmr_irq_req) else $error("timer request missing");
  clk_drive_a: assert property (take && i_opcode == `CBL_OP_CLK_OUT_EN
    |=> ##1 o_test_zero_pin_oe) else $error("test pin not driven");
  // Reset itself is the trigger here, so it cannot also disable the check
  rst_clk_off_a: assert property (disable iff (1'b0) !i_nrst
    |=> !o_test_zero_pin_oe && !o_ext_irq_en_ff) else $error("reset left outputs on");
  cover property (dbnz ##2 o_pc_ff[7:0] == $past(i_operand, 2));
  cover property (take && i_opcode == `CBL_OP_DEC_ADJ);
  cover property (o_test_zero_pin_oe);
endmodule // cbl_exec_chk
bind cbl_exec cbl_exec_chk u_chk (
  .i_mclk, .i_nrst, .i_issue, .i_opcode, .i_operand, .i_op_pc, .o_ready, .o_done_ff,
  .o_acc_ff, .o_carry_ff, .o_user_flag_zero_ff, .o_user_flag_one_ff, .o_pc_ff,
  .i_tmr_overflow, .o_ext_irq_en_ff, .o_tmr_irq_en_ff, .o_tmr_irq_req, .o_test_zero_pin_oe
);
`default_nettype wire

// [testbench/complement_bcd_loop_enable_ops_tb.sv]
// Self-checking bench: random opcodes of the slice with directed corners.
// Assumes the slice core, its helper and the constants header compile first.
`timescale 1ns/10ps
`default_nettype none
`include "cbl_defs.vh"
module complement_bcd_loop_enable_ops_tb;
  logic        i_mclk, i_nrst, i_issue, i_ext_irq_n, i_tmr_overflow, i_wr, i_rd, i_test_zero_pin;
  logic [7:0]  i_opcode, i_operand, i_wdata, e_acc, rv, od, rd_v;
  logic [11:0] i_op_pc, e_pc, np;
  logic [3:0]  i_addr;
  logic [2:0]  r;
  logic        e_c, e_aux, e_f0, e_f1, e_ext, e_tmr;
  logic [7:0]  ops [0:8];
  wire         o_ready, o_done_ff, o_unknown_ff, o_carry_ff, o_aux_carry_flag_ff;
  wire         o_user_flag_zero_ff, o_user_flag_one_ff, o_ext_irq_en_ff, o_tmr_irq_en_ff;
  wire         o_ext_irq_req, o_tmr_irq_req, o_test_zero_pin_ff, o_test_zero_pin_oe;
  wire  [7:0]  o_acc_ff, o_rdata_ff;
  wire  [11:0] o_pc_ff;
  integer      seed, failures, checked, n, k;

  cbl_exec u_dut (
    .i_mclk, .i_nrst, .i_issue, .i_opcode, .i_operand, .i_op_pc, .o_ready, .o_done_ff,
    .o_unknown_ff, .o_acc_ff, .o_carry_ff, .o_aux_carry_flag_ff, .o_user_flag_zero_ff,
    .o_user_flag_one_ff, .o_pc_ff, .i_ext_irq_n, .i_tmr_overflow, .o_ext_irq_en_ff,
    .o_tmr_irq_en_ff, .o_ext_irq_req, .o_tmr_irq_req, .i_test_zero_pin,
    .o_test_zero_pin_ff, .o_test_zero_pin_oe, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata_ff
  );

  initial
  begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata_ff;
  endtask

  task automatic issue(input logic [7:0] op, input logic [7:0] opd, input logic [11:0] pc);
    integer w;
    @(posedge i_mclk);
    i_issue   <= 1'b1;
    i_opcode  <= op;
    i_operand <= opd;
    i_op_pc   <= pc;
    @(posedge i_mclk);
    i_issue <= 1'b0;
    #1;
    for (w = 0; w < 4 && o_done_ff !== 1'b1; w++)
    begin
      @(posedge i_mclk);
      #1;
    end
    check("done", o_done_ff, 12'h001);
  endtask

  // Carry out of the low step also forces the high step
  function automatic logic [8:0] dec_adj(input logic [7:0] a, input logic c, input logic aux);
    logic [8:0] t;
    logic       cc;
    t  = {1'b0, a};
    if (t[3:0] > 4'h9 || aux)
      t = t + 9'h006;
    cc = c | t[8];
    if (t[7:4] > 4'h9 || cc)
      t = {1'b0, t[7:0]} + 9'h060;
    return {cc | t[8], t[7:0]};
  endfunction

  initial
  begin
    repeat (30000) @(posedge i_mclk);
    failures++;
    stop_test;
  end

  initial
  begin
    seed = 32'h4b9b47dd;
    failures = 0;
    checked = 0;
    {i_nrst, i_issue, i_tmr_overflow, i_wr, i_rd, i_test_zero_pin} = 6'h00;
    {i_ext_irq_n, i_opcode, i_operand, i_wdata, i_op_pc, i_addr} = 41'h10000000000;
    ops = '{`CBL_OP_COMPL_ACC, `CBL_OP_COMPL_CARRY, `CBL_OP_COMPL_UF0, `CBL_OP_COMPL_UF1,
      `CBL_OP_DEC_ADJ, `CBL_OP_EXT_IRQ_EN, `CBL_OP_TMR_IRQ_EN, `CBL_OP_CLK_OUT_EN,
      `CBL_OP_DBNZ_BASE};
    repeat (20) @(posedge i_mclk);
    i_nrst <= 1'b1;
    #1;
    check("oe_rst", o_test_zero_pin_oe, 12'h000);
    for (n = 0; n < 300; n++)
    begin
      k = (n < 2) ? 8 : (n == 2) ? 4 : {$random(seed)} % 9;
      r = $random(seed);
      od = $random(seed);
      rv = (n == 0) ? 8'h02 : (n == 1) ? 8'h01 : $random(seed);
      e_acc = (n == 2) ? 8'h9B : $random(seed);
      {e_c, e_aux, e_f0, e_f1} = (n == 2) ? 4'h0 : $random(seed);
      e_pc = $random(seed);
      // First two loops sit at the last page location
      if (n < 2)
        e_pc[7:0] = 8'hFF;
      {e_ext, e_tmr} = 2'h0;
      wr(`CBL_REG_ACC, e_acc);
      wr(`CBL_REG_PSW, {e_c, e_aux, e_f0, e_f1, 4'h0});
      wr(`CBL_REG_CTRL, 8'h00);
      wr({1'b1, r}, rv);
      issue((k == 8) ? (ops[8] | r) : ops[k], od, e_pc);
      case (k)
        0: e_acc = ~e_acc;
        1: e_c = ~e_c;
        2: e_f0 = ~e_f0;
        3: e_f1 = ~e_f1;
        4: {e_c, e_acc} = dec_adj(e_acc, e_c, e_aux);
        5: e_ext = 1'b1;
        6: e_tmr = 1'b1;
        default: ;
      endcase
      np = e_pc + 12'h001;
      e_pc = np;
      if (k == 8)
      begin
        rv = rv - 8'h01;
        e_pc = (rv != 8'h00) ? {np[11:8], od} : np + 12'h001;
        rd({1'b1, r}, rd_v);
        check("loop_reg", rd_v, rv);
      end
      check("acc", o_acc_ff, e_acc);
      check("carry", o_carry_ff, e_c);
      check("uf0", o_user_flag_zero_ff, e_f0);
      check("uf1", o_user_flag_one_ff, e_f1);
      if (k != 4)
        check("aux", o_aux_carry_flag_ff, e_aux);
      check("pc", o_pc_ff, e_pc);
      check("ext_en", o_ext_irq_en_ff, e_ext);
      check("tmr_en", o_tmr_irq_en_ff, e_tmr);
      check("known", o_unknown_ff, 12'h000);
    end
    rd(4'h6, rd_v);
    check("unmapped", rd_v, 12'h000);
    // Opcode outside the slice only steps the PC
    issue(8'h00, 8'h00, 12'h030);
    check("unknown", o_unknown_ff, 12'h001);
    check("pc_unknown", o_pc_ff, 12'h031);
    issue(`CBL_OP_EXT_IRQ_EN, 8'h00, 12'h010);
    @(posedge i_mclk);
    i_ext_irq_n <= 1'b0;
    #1;
    check("ext_req", o_ext_irq_req, 12'h001);
    @(posedge i_mclk);
    i_ext_irq_n <= 1'b1;
    issue(`CBL_OP_TMR_IRQ_EN, 8'h00, 12'h011);
    @(posedge i_mclk);
    i_tmr_overflow  <= 1'b1;
    i_test_zero_pin <= 1'b1;
    @(posedge i_mclk);
    i_tmr_overflow <= 1'b0;
    #1;
    check("tmr_req", o_tmr_irq_req, 12'h001);
    rd(`CBL_REG_STAT, rd_v);
    check("stat", rd_v, 12'h009);
    wr(`CBL_REG_STAT, 8'h01);
    rd(`CBL_REG_STAT, rd_v);
    check("stat_clr", rd_v, 12'h008);
    // test pin clock on, then off by reset
    issue(`CBL_OP_CLK_OUT_EN, 8'h00, 12'h020);
    @(posedge i_mclk);
    #1;
    check("oe_on", o_test_zero_pin_oe, 12'h001);
    rd_v[0] = o_test_zero_pin_ff;
    @(posedge i_mclk);
    #1;
    check("pin_toggle", o_test_zero_pin_ff, !rd_v[0]);
    @(posedge i_mclk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_mclk);
    #1;
    check("oe_off", o_test_zero_pin_oe, 12'h000);
    stop_test;
  end
endmodule // complement_bcd_loop_enable_ops_tb
`default_nettype wire
